// >>> hw/bps_pkg.sv
// Package: constants, states and timing for the board power sequencer.
`default_nettype none
package bps_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ          = 25;         // System clock rate in MHz.
    localparam int          STEP_DELAY_US    = 1000;       // Settle time between group steps, in us.
    localparam int          STEP_CYCLES      = STEP_DELAY_US * CLK_MHZ; // Default settle count in cycles.
    localparam int          DISCH_DELAY_US   = 10000;      // Discharge hold time after power-down, in us.
    localparam int          DISCH_CYCLES     = DISCH_DELAY_US * CLK_MHZ; // Default discharge count.
    localparam int          POLL_DELAY_US    = 100;        // Spacing between sensor poll requests, in us.
    localparam int          POLL_CYCLES      = POLL_DELAY_US * CLK_MHZ; // Poll spacing in cycles.
    localparam int          CNT_W            = 24;         // Width of the shared delay counter.

    // ------------------------------------------------------------------
    // Rail groups and monitored channels
    // ------------------------------------------------------------------
    localparam int          NUM_GROUPS       = 3;          // Sequencing groups.
    localparam int          NUM_CH           = 6;          // Monitored voltage channels.
    localparam int          CH_W             = 3;          // Channel index width.
    localparam logic [CH_W-1:0] LAST_CH      = 3'h5;       // Highest channel index.
    localparam int          VOLT_W           = 16;         // Reading width.
    localparam int          NUM_DISCH        = 12;         // Fast-discharge transistors.
    localparam logic [NUM_DISCH-1:0] DISCH_ALL = 12'hFFF;  // All discharge gates on.
    localparam logic [NUM_DISCH-1:0] DISCH_NONE = 12'h000; // All discharge gates off.

    // ------------------------------------------------------------------
    // Temperature thresholds in whole degrees C
    // ------------------------------------------------------------------
    localparam int          TEMP_W           = 8;
    localparam logic [TEMP_W-1:0] TEMP_FAN_C  = 8'h3C;     // 60 C.
    localparam logic [TEMP_W-1:0] TEMP_TRIP_C = 8'h64;     // 100 C.

    // Sequencer states.
    typedef enum logic [3:0] {
        ST_OFF, ST_UP1, ST_UP2, ST_UP3, ST_ON,
        ST_DN3, ST_DN2, ST_DN1, ST_DISCH, ST_TRIPPED
    } bps_state_t;

endpackage
`default_nettype wire

// >>> hw/bps_sequencer.sv
// Board power sequencer: ordered rail enables, discharge, polling and thermal guard.
// Operation
// - Power-up enables groups one, two, three.
// - Power-down disables groups three, two, one.
// - Group one: core and transceiver rails together.
// - Group two: pump, backup, IO, analog rails.
// - Poll ADC and regulators for six rails.
// - Discharge transistors on during power-down.
// - Die temperature monitored continuously.
// - Above 60 C force maximum cooling.
// - Above 100 C power the board off.
`timescale 1ns/1ps
`default_nettype none

module bps_sequencer
    import bps_pkg::*;
#(
    parameter int STEP_CNT  = bps_pkg::STEP_CYCLES,   // Settle cycles between steps.
    parameter int DISCH_CNT = bps_pkg::DISCH_CYCLES,  // Discharge hold cycles.
    parameter int POLL_CNT  = bps_pkg::POLL_CYCLES    // Poll spacing cycles.
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              powerOnReq,   // Level: high asks for rails on.
    input  wire logic [bps_pkg::TEMP_W-1:0]        dieTemp,      // Die temperature from diode monitor.
    input  wire logic                              dieTempValid, // Pulse: dieTemp holds a new reading.
    input  wire logic [bps_pkg::TEMP_W-1:0]        tileTemp,     // Hottest on-die sensor reading.
    input  wire logic                              sensorAck,    // Pulse: poll finished on the I2C side.
    input  wire logic [bps_pkg::VOLT_W-1:0]        sensorData,   // Reading returned with sensorAck.
    output logic [bps_pkg::NUM_GROUPS-1:0]         groupEn,      // Regulator enables, bit 0 is group one.
    output logic [bps_pkg::NUM_DISCH-1:0]          dischargeEn,  // Fast-discharge gate drives.
    output logic                                   fanMax,       // Maximum cooling command.
    output logic                                   thermalTrip,  // Sticky over-temperature shutdown.
    output logic                                   powerGood,    // All groups on and settled.
    output logic                                   sensorReq,    // Pulse: start a poll of sensorCh.
    output logic [bps_pkg::CH_W-1:0]               sensorCh,     // Channel being polled.
    output logic [bps_pkg::VOLT_W-1:0]             railVolt,     // Last reading.
    output logic [bps_pkg::CH_W-1:0]               railVoltCh,   // Channel of railVolt.
    output logic                                   railVoltValid // Pulse: railVolt updated.
);

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    bps_state_t                    state_ff, nxt_state;     // Current sequence step.
    logic [CNT_W-1:0]              delay_ff, nxt_delay;     // Settle or discharge countdown.
    logic [NUM_GROUPS-1:0]         groupEn_ff, nxt_groupEn; // Regulator enables.
    logic [NUM_DISCH-1:0]          disch_ff, nxt_disch;     // Discharge gates.
    logic                          good_ff, nxt_good;       // Power good.
    logic                          trip_ff, nxt_trip;       // Latched thermal shutdown.
    logic                          fan_ff, nxt_fan;         // Cooling command.
    logic [TEMP_W-1:0]             dieT_ff, nxt_dieT;       // Latest die temperature.
    logic [TEMP_W-1:0]             hot;                     // Hottest of the two sources.
    logic                          overTrip;                // Above the shutdown threshold.

    // Hottest sensor decides both the fan and the trip.
    always_comb begin
        hot      = (dieT_ff > tileTemp) ? dieT_ff : tileTemp;
        overTrip = (hot > TEMP_TRIP_C);
    end

    // Thermal tracking; the trip latches so a hot board stays off until reset.
    always_comb begin
        nxt_dieT = dieT_ff;
        if (dieTempValid) begin
            nxt_dieT = dieTemp;
        end
        nxt_fan  = (hot > TEMP_FAN_C);
        nxt_trip = trip_ff | overTrip;
    end

    // Next-state logic of the sequencer.
    always_comb begin
        nxt_state   = state_ff;
        nxt_delay   = (delay_ff != '0) ? delay_ff - 1'b1 : delay_ff;
        nxt_groupEn = groupEn_ff;
        nxt_disch   = disch_ff;
        nxt_good    = 1'b0;
        case (state_ff)
            ST_OFF: begin
                nxt_disch = DISCH_NONE;
                if (powerOnReq && !trip_ff && !overTrip) begin
                    nxt_groupEn = 3'b001;
                    nxt_delay   = CNT_W'(STEP_CNT);
                    nxt_state   = ST_UP1;
                end
            end
            ST_UP1: begin
                if (!powerOnReq || overTrip) begin
                    nxt_state = ST_DN1;
                end else if (delay_ff == '0) begin
                    nxt_groupEn = 3'b011;
                    nxt_delay   = CNT_W'(STEP_CNT);
                    nxt_state   = ST_UP2;
                end
            end
            ST_UP2: begin
                if (!powerOnReq || overTrip) begin
                    nxt_state = ST_DN2;
                end else if (delay_ff == '0) begin
                    nxt_groupEn = 3'b111;
                    nxt_delay   = CNT_W'(STEP_CNT);
                    nxt_state   = ST_UP3;
                end
            end
            ST_UP3: begin
                if (!powerOnReq || overTrip) begin
                    nxt_state = ST_DN3;
                end else if (delay_ff == '0) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                nxt_good = 1'b1;
                if (!powerOnReq || overTrip) begin
                    nxt_good  = 1'b0;
                    nxt_state = ST_DN3;
                end
            end
            // Each down step drops one group and waits; a partly raised set
            // enters at its own top group so order stays reversed.
            ST_DN3: begin
                nxt_groupEn = 3'b011;
                nxt_delay   = CNT_W'(STEP_CNT);
                nxt_state   = ST_DN2;
            end
            ST_DN2: begin
                if (groupEn_ff[2] || delay_ff == '0) begin
                    nxt_groupEn = 3'b001;
                    nxt_delay   = CNT_W'(STEP_CNT);
                    nxt_state   = ST_DN1;
                end
            end
            ST_DN1: begin
                if (groupEn_ff[1] || delay_ff == '0) begin
                    nxt_groupEn = 3'b000;
                    nxt_delay   = CNT_W'(DISCH_CNT);
                    nxt_state   = ST_DISCH;
                end
            end
            ST_DISCH: begin
                // Gates open only after every regulator enable is low.
                nxt_disch = DISCH_ALL;
                if (delay_ff == '0) begin
                    nxt_disch = DISCH_NONE;
                    nxt_state = trip_ff ? ST_TRIPPED : ST_OFF;
                end
            end
            ST_TRIPPED: begin
                // Only a reset (power cycle) leaves this state.
                nxt_disch = DISCH_NONE;
            end
            default: begin
                nxt_state   = ST_OFF;
                nxt_groupEn = '0;
                nxt_disch   = DISCH_NONE;
            end
        endcase
    end

    // Sequencer and thermal registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff   <= ST_OFF;
            delay_ff   <= '0;
            groupEn_ff <= '0;
            disch_ff   <= DISCH_NONE;
            good_ff    <= 1'b0;
            trip_ff    <= 1'b0;
            fan_ff     <= 1'b0;
            dieT_ff    <= '0;
        end else begin
            state_ff   <= nxt_state;
            delay_ff   <= nxt_delay;
            groupEn_ff <= nxt_groupEn;
            disch_ff   <= nxt_disch;
            good_ff    <= nxt_good;
            trip_ff    <= nxt_trip;
            fan_ff     <= nxt_fan;
            dieT_ff    <= nxt_dieT;
        end
    end

    // ------------------------------------------------------------------
    // Voltage polling
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]   poll_ff, nxt_poll;     // Spacing countdown.
    logic               busy_ff, nxt_busy;     // Poll outstanding.
    logic               req_ff, nxt_req;       // Request pulse.
    logic [CH_W-1:0]    ch_ff, nxt_ch;         // Channel pointer.
    logic [VOLT_W-1:0]  volt_ff, nxt_volt;     // Captured reading.
    logic [CH_W-1:0]    vch_ff, nxt_vch;       // Channel of reading.
    logic               vval_ff, nxt_vval;     // Reading pulse.

    // Round-robin over the six rails; one poll outstanding at a time so a
    // slow I2C answer simply stretches the cycle rather than piling up.
    always_comb begin
        nxt_poll = (poll_ff != '0) ? poll_ff - 1'b1 : poll_ff;
        nxt_busy = busy_ff;
        nxt_req  = 1'b0;
        nxt_ch   = ch_ff;
        nxt_volt = volt_ff;
        nxt_vch  = vch_ff;
        nxt_vval = 1'b0;
        if (busy_ff) begin
            if (sensorAck) begin
                nxt_volt = sensorData;
                nxt_vch  = ch_ff;
                nxt_vval = 1'b1;
                nxt_busy = 1'b0;
                nxt_ch   = (ch_ff == LAST_CH) ? '0 : ch_ff + 1'b1;
                nxt_poll = CNT_W'(POLL_CNT);
            end
        end else if (poll_ff == '0 && groupEn_ff != '0) begin
            nxt_req  = 1'b1;
            nxt_busy = 1'b1;
        end
    end

    // Polling registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            poll_ff <= '0;
            busy_ff <= 1'b0;
            req_ff  <= 1'b0;
            ch_ff   <= '0;
            volt_ff <= '0;
            vch_ff  <= '0;
            vval_ff <= 1'b0;
        end else begin
            poll_ff <= nxt_poll;
            busy_ff <= nxt_busy;
            req_ff  <= nxt_req;
            ch_ff   <= nxt_ch;
            volt_ff <= nxt_volt;
            vch_ff  <= nxt_vch;
            vval_ff <= nxt_vval;
        end
    end

    // Outputs straight from flip-flops.
    assign groupEn       = groupEn_ff;
    assign dischargeEn   = disch_ff;
    assign fanMax        = fan_ff;
    assign thermalTrip   = trip_ff;
    assign powerGood     = good_ff;
    assign sensorReq     = req_ff;
    assign sensorCh      = ch_ff;
    assign railVolt      = volt_ff;
    assign railVoltCh    = vch_ff;
    assign railVoltValid = vval_ff;

endmodule

`default_nettype wire

// >>> verif/board_power_sequencer_test.sv
// Testbench: self-checking run of the board power sequencer.
`timescale 1ns/1ps
`default_nettype none
module board_power_sequencer_test;
    import bps_pkg::*;
    localparam int STEP = 4; // Short settle count keeps the run brief.
    localparam int DISCH = 8; // Short discharge hold, matched by the checker's repeat count.
    typedef struct {logic [7:0] temp; logic fan;} bps_row_t;
    logic clk = 1'b0, rst_n = 1'b0, powerOnReq = 1'b0, dieTempValid = 1'b0;
    logic [7:0] dieTemp = 8'h19, tileTemp = 8'h19;
    logic sensorAck, sensorReq, fanMax, thermalTrip, powerGood, railVoltValid;
    logic [15:0] sensorData, railVolt;
    logic [2:0] sensorCh, railVoltCh, groupEn, expCh;
    logic [11:0] dischargeEn;
    int err_count = 0, num_checks = 0, polls = 0;
    // Fan rows straddle the threshold; 100 stays just below the trip.
    bps_row_t rows [4] = '{'{8'h3C, 1'b0}, '{8'h3D, 1'b1}, '{8'h64, 1'b1}, '{8'h1E, 1'b0}};
    always #20 clk = ~clk;
    bps_sequencer #(.STEP_CNT(STEP), .DISCH_CNT(DISCH), .POLL_CNT(2)) DUT (.clk(clk), .rst_n(rst_n),
        .powerOnReq(powerOnReq), .dieTemp(dieTemp), .dieTempValid(dieTempValid), .tileTemp(tileTemp),
        .sensorAck(sensorAck), .sensorData(sensorData), .groupEn(groupEn), .dischargeEn(dischargeEn),
        .fanMax(fanMax), .thermalTrip(thermalTrip), .powerGood(powerGood), .sensorReq(sensorReq),
        .sensorCh(sensorCh), .railVolt(railVolt), .railVoltCh(railVoltCh), .railVoltValid(railVoltValid));
    bps_sensor_model u_sensor (.clk(clk), .rst_n(rst_n), .sensorReq(sensorReq), .sensorCh(sensorCh),
        .sensorAck(sensorAck), .sensorData(sensorData));
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Waits for a group pattern; n above zero also fixes the edge count.
    task automatic waitGrp(input logic [2:0] g, input int n);
        int k;
        k = 0;
        while (groupEn !== g && k < 40) begin
            tick(1);
            k++;
        end
        check(groupEn === g && (n == 0 || k == n), "group step");
    endtask
    task automatic doReset;
        @(posedge clk) rst_n <= 1'b0;
        tick(5);
        check({groupEn, dischargeEn, fanMax, thermalTrip, powerGood, sensorReq} === 19'h0, "reset outputs");
        @(posedge clk) rst_n <= 1'b1;
        #1;
    endtask
    task automatic powerUp;
        @(posedge clk) powerOnReq <= 1'b1;
        #1;
        waitGrp(3'h1, 0);
        waitGrp(3'h3, STEP + 1);
        waitGrp(3'h7, STEP + 1);
        tick(STEP + 1);
        check(powerGood === 1'b0, "power good early");
        tick(1);
        check(powerGood === 1'b1 && dischargeEn === DISCH_NONE, "power good");
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Every reading must match its channel, and channels go round in turn.
    // Looked at on the falling edge, where the registered pulse has settled.
    always @(negedge clk) begin
        if (!rst_n) begin
            expCh <= 3'h0;
        end else if (railVoltValid === 1'b1) begin
            check(railVoltCh === expCh && railVolt === {13'h1400, expCh}, "poll reading");
            expCh <= (expCh == LAST_CH) ? 3'h0 : expCh + 3'h1;
            polls++;
        end
    end
    initial begin
        #(40 * 3000);
        err_count++;
        $display("[FAIL] %0t watchdog", $time);
        print_verdict();
    end
    initial begin
        doReset();
        foreach (rows[i]) begin
            @(posedge clk) tileTemp <= rows[i].temp;
            tick(2);
            check(fanMax === rows[i].fan, "fan vs tile temperature");
        end
        @(posedge clk) {dieTemp, dieTempValid} <= {8'h3D, 1'b1};
        @(posedge clk) {dieTemp, dieTempValid} <= {8'h19, 1'b0};
        tick(3);
        check(fanMax === 1'b1, "die reading not held");
        @(posedge clk) dieTempValid <= 1'b1;
        @(posedge clk) dieTempValid <= 1'b0;
        tick(3);
        check(fanMax === 1'b0, "fan stuck after cool die");
        powerUp();
        tick(80);
        check(polls >= 7, "too few polls");
        @(posedge clk) powerOnReq <= 1'b0;
        #1;
        waitGrp(3'h3, 0);
        waitGrp(3'h1, STEP + 1);
        waitGrp(3'h0, STEP + 1);
        check(dischargeEn === DISCH_NONE, "discharge before rail off");
        tick(1);
        check(dischargeEn === DISCH_ALL, "discharge off");
        // The gates must stand for the whole hold and drop right after it.
        tick(DISCH - 1);
        check(dischargeEn === DISCH_ALL, "discharge ended early");
        tick(1);
        check(dischargeEn === DISCH_NONE, "discharge stuck");
        tick(3);
        powerUp();
        @(posedge clk) tileTemp <= 8'h65;
        #1;
        waitGrp(3'h3, 0);
        check(thermalTrip === 1'b1, "no trip");
        waitGrp(3'h0, 0);
        @(posedge clk) tileTemp <= 8'h19;
        tick(30);
        check(groupEn === 3'h0 && thermalTrip === 1'b1, "power-on after trip");
        doReset();
        waitGrp(3'h1, 0);
        // A request dropped in the first step takes only group one down, then discharges.
        @(posedge clk) powerOnReq <= 1'b0;
        #1;
        waitGrp(3'h0, 0);
        tick(1);
        check(dischargeEn === DISCH_ALL, "discharge after early drop");
        tick(DISCH);
        check(dischargeEn === DISCH_NONE, "discharge stuck after early drop");
        // A board that is already too hot refuses power-on and latches the trip.
        @(posedge clk) {tileTemp, powerOnReq} <= {8'h65, 1'b1};
        tick(STEP);
        check(groupEn === 3'h0 && thermalTrip === 1'b1, "power-on while hot");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/bps_sensor_model.sv
// Sensor-side model: answers each poll after a prompt or a slow delay.
`timescale 1ns/1ps
`default_nettype none
module bps_sensor_model
    import bps_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      sensorReq,
    input  wire logic [bps_pkg::CH_W-1:0]  sensorCh,
    output logic                           sensorAck,
    output logic [bps_pkg::VOLT_W-1:0]     sensorData
);
    logic [2:0]      waitCnt; // Cycles left before the answer.
    logic            busy;    // A poll is being served.
    logic            slow;    // Alternates prompt and slow answers.
    logic [CH_W-1:0] chHeld;  // Channel asked for.
    // Outside an answer the data toggles, so a stale value never looks valid.
    always @(posedge clk) begin
        sensorAck <= 1'b0;
        sensorData <= ~sensorData;
        if (!rst_n) begin
            busy <= 1'b0;
            slow <= 1'b0;
            sensorData <= 16'h0000;
        end else if (sensorReq) begin
            busy <= 1'b1;
            chHeld <= sensorCh;
            waitCnt <= slow ? 3'h4 : 3'h0;
            slow <= !slow;
        end else if (busy && waitCnt == 3'h0) begin
            busy <= 1'b0;
            sensorAck <= 1'b1;
            sensorData <= {13'h1400, chHeld};
        end else if (busy) begin
            waitCnt <= waitCnt - 3'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verif/bps_sequencer_asserts.sv
// Checker: sequencing, discharge, thermal and polling properties.
`timescale 1ns/1ps
`default_nettype none
module bps_sequencer_asserts
    import bps_pkg::*;
#(
    parameter int STEP_CNT  = 4,
    parameter int DISCH_CNT = 8,
    parameter int POLL_CNT  = 2
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [TEMP_W-1:0]     tileTemp,
    input wire logic                  sensorAck,
    input wire logic [VOLT_W-1:0]     sensorData,
    input wire logic [NUM_GROUPS-1:0] groupEn,
    input wire logic [NUM_DISCH-1:0]  dischargeEn,
    input wire logic                  fanMax,
    input wire logic                  thermalTrip,
    input wire logic                  powerGood,
    input wire logic                  sensorReq,
    input wire logic [CH_W-1:0]       sensorCh,
    input wire logic [VOLT_W-1:0]     railVolt,
    input wire logic [CH_W-1:0]       railVoltCh,
    input wire logic                  railVoltValid
);
    logic pend_ff;  // A poll is outstanding, so an ack is meaningful.
    logic nxt_pend; // Next value of the outstanding flag.
    always_comb nxt_pend = sensorReq | (pend_ff & ~sensorAck);
    always_ff @(posedge clk) pend_ff <= rst_n & nxt_pend;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_upTwo;
        groupEn == 3'h3 && $past(groupEn) == 3'h1;
    endsequence
    sequence s_lastOff;
        groupEn == 3'h0 && $past(groupEn) == 3'h1;
    endsequence
    // Only the four staircase patterns may ever show on the enables.
    chk_group_legal: assert property (groupEn inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("group enables not a legal step");
    chk_up_spacing: assert property (s_upTwo |-> $past(groupEn, STEP_CNT + 1) == 3'h1)
        else $error("group two came early");
    chk_up_order: assert property (groupEn > $past(groupEn) |-> groupEn == {$past(groupEn[1:0]), 1'b1})
        else $error("groups rose out of order");
    chk_down_order: assert property (groupEn < $past(groupEn) |-> groupEn == ($past(groupEn) >> 1))
        else $error("groups fell out of order");
    chk_disch_late: assert property (dischargeEn != DISCH_NONE |-> groupEn == 3'h0)
        else $error("discharge while a rail is on");
    // The hold count below equals DISCH_CNT as the bench sets it.
    chk_disch_hold: assert property (s_lastOff |=> dischargeEn == DISCH_ALL [*8])
        else $error("discharge not held after power-down");
    chk_fan_hot: assert property (tileTemp > TEMP_FAN_C |=> fanMax)
        else $error("fan not at maximum");
    chk_trip_set: assert property (tileTemp > TEMP_TRIP_C |=> thermalTrip)
        else $error("trip not set");
    chk_trip_hold: assert property (thermalTrip |=> thermalTrip)
        else $error("trip cleared without reset");
    // Leaving the on state and dropping group three are one register stage apart.
    chk_trip_down: assert property (tileTemp > TEMP_TRIP_C && groupEn == 3'h7 |=> ##1 groupEn == 3'h3)
        else $error("hot board not powered down");
    chk_good_all: assert property (powerGood |-> groupEn == 3'h7)
        else $error("power good with rails off");
    chk_poll_pulse: assert property (sensorReq |=> !sensorReq)
        else $error("poll request longer than a cycle");
    chk_volt_ret: assert property (sensorAck && pend_ff |=> railVoltValid && railVolt == $past(sensorData)
        && railVoltCh == $past(sensorCh))
        else $error("reading not returned");
endmodule
bind bps_sequencer bps_sequencer_asserts #(.STEP_CNT(STEP_CNT), .DISCH_CNT(DISCH_CNT), .POLL_CNT(POLL_CNT)) u_chk (
    .clk(clk), .rst_n(rst_n), .tileTemp(tileTemp), .sensorAck(sensorAck), .sensorData(sensorData),
    .groupEn(groupEn), .dischargeEn(dischargeEn), .fanMax(fanMax), .thermalTrip(thermalTrip),
    .powerGood(powerGood), .sensorReq(sensorReq), .sensorCh(sensorCh), .railVolt(railVolt),
    .railVoltCh(railVoltCh), .railVoltValid(railVoltValid));
`default_nettype wire
